// [core/flash_engine.sv]
// serial nor flash instruction engine: reads, page program, erase
// assumes select, serial clock and io lines arrive from pins (async)
// Summary of operation
// - 03h plus address streams data, no dummy
// - reads stream incrementing bytes until select rises
// - read pointer wraps from top to zero
// - 0bh reads after one dummy byte
// - 3bh: serial command/address, dual data out
// - dual out: odd bits line1, even line0
// - bbh: address and dummy on two lines
// - dual address pairs latched same rising edge
// - page program starts when select rises
// - partial program byte is discarded
// - only last 256 program bytes kept
// - program column wraps within page
// - protected program or erase is ignored
// - 20h/d7h erases addressed 4 KiB sector
// - d8h erases addressed 64 KiB block
// - 60h/c7h erases whole array
// - chip erase ignored if any protection
// - erase starts at select rise, busy shown
// - bits sampled on rising clock, msb first
// - early select rise abandons instruction
// - dual bus cycle takes four clocks
// - 06h sets write enable latch
`timescale 1ns/1ps
module flash_engine #(
   parameter int ADDR_W = 20,
   parameter int unsigned PP_CYCLES = flash_pkg::PAGE_PROGRAM_CYCLES,
   parameter int unsigned SE_CYCLES = flash_pkg::SECTOR_ERASE_CYCLES,
   parameter int unsigned BE_CYCLES = flash_pkg::BLOCK_ERASE_CYCLES,
   parameter int unsigned CE_CYCLES = flash_pkg::CHIP_ERASE_CYCLES
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic sel_n_i,
   input wire logic sck_i,
   input wire logic io_line_0_i,
   output logic io_line_0_o,
   output logic io_line_0_oe_o,
   input wire logic io_line_1_i,
   output logic io_line_1_o,
   output logic io_line_1_oe_o,
   input wire logic protect_en_i,
   input wire logic [23:0] protect_from_i,
   output logic busy_o,
   output logic write_enable_o
);
   import flash_pkg::*;

   logic [7:0] mem_q [2**ADDR_W];
   logic [7:0] pbuf_q [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pvalid_q;

   // pin synchroniser: three stages, a change counts when 2nd and 3rd agree
   pin_sample_s s1_q, s2_q, s3_q, stab_q, stab_d;
   logic rise, fall, sel_rise, d0, d1;

   always_comb begin
      stab_d = pin_sample_s'((s2_q & s3_q) | (stab_q & (s2_q ^ s3_q)));
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         // idle levels, so releasing reset shows no false clock edge
         s1_q <= PIN_IDLE;
         s2_q <= PIN_IDLE;
         s3_q <= PIN_IDLE;
         stab_q <= PIN_IDLE;
      end else begin
         s1_q <= {sel_n_i, sck_i, io_line_1_i, io_line_0_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
         stab_q <= stab_d;
      end
   end

   assign rise = stab_d.sck & ~stab_q.sck & ~stab_q.sel_n;
   assign fall = ~stab_d.sck & stab_q.sck & ~stab_q.sel_n;
   assign sel_rise = stab_d.sel_n & ~stab_q.sel_n;
   assign d0 = stab_d.d0;
   assign d1 = stab_d.d1;

   // link state
   link_state_e st_q, st_d;
   logic [4:0] cnt_q, cnt_d;
   logic [7:0] op_q, op_d;
   logic [23:0] sh_q, sh_d;
   logic [7:0] col_q, col_d;
   logic [7:0] osh_q, osh_d;
   logic [2:0] ocnt_q, ocnt_d;
   logic o0_q, o0_d, o1_q, o1_d, oe0_q, oe0_d, oe1_q, oe1_d;
   logic wel_q, wel_d;
   logic [ADDR_W-1:0] fptr_q, fptr_d;
   logic fen_q, fen_d;
   logic [7:0] op_byte;
   logic [23:0] sh_next;
   logic dual_io, dual_out, is_read, is_write, pb_clr, pb_we, pop;
   logic [7:0] pb_wd;
   op_req_s launch;

   // fifo between array fetch and output shifter
   logic f_in_valid, f_in_ready, f_out_valid, f_flush;
   logic [7:0] f_out_data;

   // busy engine state
   logic e_busy_q, e_busy_d, e_done;
   op_kind_e e_kind_q, e_kind_d;
   logic [ADDR_W-1:0] e_base_q, e_base_d, e_walk_q, e_walk_d, mem_wa;
   logic [24:0] e_left_q, e_left_d;
   logic [31:0] e_timer_q, e_timer_d;
   logic mem_we;
   logic [7:0] mem_wd;

   function automatic logic hits_prot(input logic [23:0] a);
      hits_prot = protect_en_i && (a >= protect_from_i);
   endfunction

   assign op_byte = {sh_q[6:0], d0};
   assign dual_io = (op_q == OP_DUAL_IO);
   assign dual_out = dual_io | (op_q == OP_DUAL_OUT);
   assign sh_next = dual_io ? {sh_q[21:0], d1, d0} : {sh_q[22:0], d0};
   assign is_read = (op_byte == OP_READ) | (op_byte == OP_FAST_READ) |
                    (op_byte == OP_DUAL_OUT) | (op_byte == OP_DUAL_IO);
   assign is_write = (op_byte == OP_PAGE_PROG) |
                     (op_byte == OP_SECTOR_ERASE_A) |
                     (op_byte == OP_SECTOR_ERASE_B) |
                     (op_byte == OP_BLOCK_ERASE);
   assign pop = fall & (st_q == L_READ) & (ocnt_q == '0) & f_out_valid;
   assign f_in_valid = fen_q;
   assign f_flush = sel_rise | (st_d == L_READ && st_q != L_READ);

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      op_d = op_q;
      sh_d = sh_q;
      col_d = col_q;
      osh_d = osh_q;
      ocnt_d = ocnt_q;
      o0_d = o0_q;
      o1_d = o1_q;
      oe0_d = oe0_q;
      oe1_d = oe1_q;
      wel_d = wel_q;
      fptr_d = fptr_q;
      fen_d = fen_q;
      pb_clr = 1'b0;
      pb_we = 1'b0;
      pb_wd = {sh_q[6:0], d0};
      launch = '0;
      if (e_done) begin
         wel_d = 1'b0;
      end
      if (fen_q && f_in_ready) begin
         fptr_d = fptr_q + 1'b1;
      end
      if (sel_rise) begin
         // whole instructions only take effect here; anything else aborts
         case (st_q)
            L_HOLD: begin
               if (op_q == OP_WRITE_ENABLE) begin
                  wel_d = 1'b1;
               end else if (op_q == OP_CHIP_ERASE_A ||
                            op_q == OP_CHIP_ERASE_B) begin
                  if (!protect_en_i) begin
                     launch.kind = OP_ERASE;
                     launch.len = 25'(2**ADDR_W);
                     launch.cycles = CE_CYCLES;
                  end
               end else if (op_q == OP_BLOCK_ERASE) begin
                  launch.base = sh_q & ~24'(BLOCK_BYTES - 1);
                  launch.len = 25'(BLOCK_BYTES);
                  launch.cycles = BE_CYCLES;
                  if (!hits_prot(sh_q | 24'(BLOCK_BYTES - 1))) begin
                     launch.kind = OP_ERASE;
                  end
               end else begin
                  launch.base = sh_q & ~24'(SECTOR_BYTES - 1);
                  launch.len = 25'(SECTOR_BYTES);
                  launch.cycles = SE_CYCLES;
                  if (!hits_prot(sh_q | 24'(SECTOR_BYTES - 1))) begin
                     launch.kind = OP_ERASE;
                  end
               end
            end
            L_PROG: begin
               // partial byte in sh_q never reached the page buffer
               launch.base = sh_q & ~24'(PAGE_BYTES - 1);
               launch.len = 25'(PAGE_BYTES);
               launch.cycles = PP_CYCLES;
               if (pvalid_q != '0 &&
                   !hits_prot(sh_q | 24'(PAGE_BYTES - 1))) begin
                  launch.kind = OP_PROG;
               end
            end
            default: begin
            end
         endcase
         st_d = L_OPCODE;
         cnt_d = '0;
         oe0_d = 1'b0;
         oe1_d = 1'b0;
         fen_d = 1'b0;
         ocnt_d = '0;
      end else if (rise) begin
         case (st_q)
            L_OPCODE: begin
               sh_d = {sh_q[22:0], d0};
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == BYTE_LAST) begin
                  op_d = op_byte;
                  cnt_d = '0;
                  // writes need the latch, nothing is taken while busy
                  if (e_busy_q) begin
                     st_d = L_SKIP;
                  end else if (is_read) begin
                     st_d = L_ADDR;
                  end else if (is_write) begin
                     st_d = wel_q ? L_ADDR : L_SKIP;
                  end else if (op_byte == OP_CHIP_ERASE_A ||
                               op_byte == OP_CHIP_ERASE_B) begin
                     st_d = wel_q ? L_HOLD : L_SKIP;
                  end else if (op_byte == OP_WRITE_ENABLE) begin
                     st_d = L_HOLD;
                  end else begin
                     st_d = L_SKIP;
                  end
               end
            end
            L_ADDR: begin
               sh_d = sh_next;
               cnt_d = cnt_q + (dual_io ? 5'h02 : 5'h01);
               if (cnt_q == (dual_io ? ADDR_LAST_DUAL : ADDR_LAST_SINGLE))
                  begin
                  cnt_d = '0;
                  if (op_q == OP_READ) begin
                     st_d = L_READ;
                     fptr_d = sh_next[ADDR_W-1:0];
                     fen_d = 1'b1;
                  end else if (op_q == OP_PAGE_PROG) begin
                     st_d = L_PROG;
                     col_d = sh_next[7:0];
                     pb_clr = 1'b1;
                  end else if (op_q == OP_FAST_READ ||
                               op_q == OP_DUAL_OUT || dual_io) begin
                     st_d = L_DUMMY;
                  end else begin
                     st_d = L_HOLD;
                  end
               end
            end
            L_DUMMY: begin
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == (dual_io ? DUMMY_LAST_DUAL : BYTE_LAST)) begin
                  st_d = L_READ;
                  cnt_d = '0;
                  fptr_d = sh_q[ADDR_W-1:0];
                  fen_d = 1'b1;
               end
            end
            L_PROG: begin
               sh_d = {sh_q[23:8], sh_q[6:0], d0};
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == BYTE_LAST) begin
                  cnt_d = '0;
                  pb_we = 1'b1;
                  col_d = col_q + 1'b1;
               end
            end
            default: begin
            end
         endcase
      end else if (fall && st_q == L_READ) begin
         oe1_d = 1'b1;
         oe0_d = dual_out;
         if (ocnt_q == '0) begin
            osh_d = {f_out_data[5:0], 2'b00};
            o1_d = f_out_data[7];
            o0_d = f_out_data[6];
            ocnt_d = dual_out ? 3'h3 : 3'h7;
            if (!dual_out) begin
               osh_d = {f_out_data[6:0], 1'b0};
            end
         end else begin
            o1_d = osh_q[7];
            o0_d = osh_q[6];
            osh_d = dual_out ? {osh_q[5:0], 2'b00} : {osh_q[6:0], 1'b0};
            ocnt_d = ocnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_q <= L_OPCODE;
         cnt_q <= '0;
         op_q <= '0;
         sh_q <= '0;
         col_q <= '0;
         osh_q <= '0;
         ocnt_q <= '0;
         o0_q <= 1'b0;
         o1_q <= 1'b0;
         oe0_q <= 1'b0;
         oe1_q <= 1'b0;
         wel_q <= 1'b0;
         fptr_q <= '0;
         fen_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         op_q <= op_d;
         sh_q <= sh_d;
         col_q <= col_d;
         osh_q <= osh_d;
         ocnt_q <= ocnt_d;
         o0_q <= o0_d;
         o1_q <= o1_d;
         oe0_q <= oe0_d;
         oe1_q <= oe1_d;
         wel_q <= wel_d;
         fptr_q <= fptr_d;
         fen_q <= fen_d;
      end
   end

   // prefetch keeps the fifo topped up; it stalls when the fifo is full
   byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .flush_i(f_flush),
      .in_valid_i(f_in_valid),
      .in_ready_o(f_in_ready),
      .in_data_i(mem_q[fptr_q]),
      .out_valid_o(f_out_valid),
      .out_ready_i(pop),
      .out_data_o(f_out_data)
   );

   // self-timed engine: walks the range once while the timer counts down; done when both reach zero
   always_comb begin
      e_busy_d = e_busy_q;
      e_kind_d = e_kind_q;
      e_base_d = e_base_q;
      e_walk_d = e_walk_q;
      e_left_d = e_left_q;
      e_timer_d = e_timer_q;
      e_done = 1'b0;
      mem_we = 1'b0;
      mem_wa = e_base_q + e_walk_q;
      mem_wd = ERASED_BYTE;
      if (launch.kind != OP_NONE) begin
         e_busy_d = 1'b1;
         e_kind_d = launch.kind;
         e_base_d = launch.base[ADDR_W-1:0];
         e_walk_d = '0;
         e_left_d = launch.len;
         e_timer_d = launch.cycles;
      end else if (e_busy_q) begin
         if (e_left_q != '0) begin
            if (e_kind_q == OP_PROG) begin
               // programming can only clear bits
               mem_we = pvalid_q[e_walk_q[7:0]];
               mem_wd = mem_q[mem_wa] & pbuf_q[e_walk_q[7:0]];
            end else begin
               mem_we = 1'b1;
            end
            e_walk_d = e_walk_q + 1'b1;
            e_left_d = e_left_q - 1'b1;
         end
         if (e_timer_q != '0) begin
            e_timer_d = e_timer_q - 1'b1;
         end
         if (e_left_q == '0 && e_timer_q == '0) begin
            e_busy_d = 1'b0;
            e_done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         e_busy_q <= 1'b0;
         e_kind_q <= OP_NONE;
         e_base_q <= '0;
         e_walk_q <= '0;
         e_left_q <= '0;
         e_timer_q <= '0;
      end else begin
         e_busy_q <= e_busy_d;
         e_kind_q <= e_kind_d;
         e_base_q <= e_base_d;
         e_walk_q <= e_walk_d;
         e_left_q <= e_left_d;
         e_timer_q <= e_timer_d;
      end
   end

   // storage: array contents are not reset, as in a real flash
   always_ff @(posedge clk_i) begin
      if (mem_we) begin
         mem_q[mem_wa] <= mem_wd;
      end
      if (pb_we) begin
         pbuf_q[col_q] <= pb_wd;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || pb_clr) begin
         pvalid_q <= '0;
      end else if (pb_we) begin
         pvalid_q[col_q] <= 1'b1;
      end
   end

   assign io_line_0_o = o0_q;
   assign io_line_1_o = o1_q;
   assign io_line_0_oe_o = oe0_q;
   assign io_line_1_oe_o = oe1_q;
   assign busy_o = e_busy_q;
   assign write_enable_o = wel_q;
endmodule

// [core/flash_pkg.sv]
// constants, opcodes and types shared by the flash instruction engine
// assumes a 25 MHz system clock that samples the serial link pins
package flash_pkg;
   localparam int CLK_MHZ = 25;

   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
   localparam logic [7:0] OP_DUAL_IO = 8'hbb;
   localparam logic [7:0] OP_PAGE_PROG = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE_A = 8'h20;
   localparam logic [7:0] OP_SECTOR_ERASE_B = 8'hd7;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;

   // last value of the bit counter in each bus phase
   localparam logic [4:0] BYTE_LAST = 5'h07;
   localparam logic [4:0] ADDR_LAST_SINGLE = 5'h17;
   localparam logic [4:0] ADDR_LAST_DUAL = 5'h16;
   localparam logic [4:0] DUMMY_LAST_DUAL = 5'h03;

   localparam int PAGE_BYTES = 256;
   localparam int SECTOR_BYTES = 4096;
   localparam int BLOCK_BYTES = 65536;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // self-timed operation durations in microseconds, and in clock cycles
   localparam int PAGE_PROGRAM_TIME_US = 1000;
   localparam int SECTOR_ERASE_TIME_US = 1000;
   localparam int BLOCK_ERASE_TIME_US = 5000;
   localparam int CHIP_ERASE_TIME_US = 50000;
   localparam int PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_TIME_US * CLK_MHZ;
   localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ;
   localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
   localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * CLK_MHZ;

   localparam int FIFO_DEPTH = 8;

   typedef enum logic [2:0] {
      L_OPCODE = 3'h0,
      L_ADDR = 3'h1,
      L_DUMMY = 3'h2,
      L_READ = 3'h3,
      L_PROG = 3'h4,
      L_HOLD = 3'h5,
      L_SKIP = 3'h6
   } link_state_e;

   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_PROG = 2'h1,
      OP_ERASE = 2'h2
   } op_kind_e;

   typedef struct packed {
      logic sel_n;
      logic sck;
      logic d1;
      logic d0;
   } pin_sample_s;

   // pin levels assumed after reset: deselected, serial clock low
   localparam pin_sample_s PIN_IDLE = 4'hb;

   typedef struct packed {
      op_kind_e kind;
      logic [23:0] base;
      logic [24:0] len;
      logic [31:0] cycles;
   } op_req_s;
endpackage

// [core/byte_fifo.sv]
// small synchronous fifo with valid/ready on both sides and a flush
// assumes flush and both handshakes come from the same clock domain
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [PW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb begin
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (flush_i) begin
         wr_d = '0;
         rd_d = '0;
         cnt_d = '0;
      end else begin
         if (push) begin
            wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push && !flush_i) begin
         mem_q[wr_q] <= in_data_i;
      end
   end
endmodule

// [tb/flash_engine_props.sv]
// assertions on the flash engine's link enables and write status
// assumes binding onto flash_engine; one clock domain, sync reset
`timescale 1ns/1ps
module flash_engine_props (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic sel_n_i,
   input wire logic io_line_0_oe_o,
   input wire logic io_line_1_oe_o,
   input wire logic busy_o,
   input wire logic write_enable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   AST_OE_IDLE:
   assert property (sel_n_i [*8] |-> !io_line_1_oe_o)
      else $error("output on while deselected");
   AST_OE_DROP:
   assert property ($rose(sel_n_i) |-> ##[1:6] !io_line_1_oe_o)
      else $error("output kept after select rise");
   AST_DUAL_PAIR:
   assert property (io_line_0_oe_o |-> io_line_1_oe_o)
      else $error("line 0 driven without line 1");
   AST_OE_SEL:
   assert property ($rose(io_line_1_oe_o) |-> !$past(sel_n_i, 4))
      else $error("output began without a frame");
   AST_BUSY_WEL:
   assert property ($rose(busy_o) |-> write_enable_o)
      else $error("operation began without latch");
   AST_BUSY_MIN:
   assert property ($rose(busy_o) |-> busy_o [*8])
      else $error("busy too short");
   AST_BUSY_SEL:
   assert property ($rose(busy_o) |-> sel_n_i && $past(sel_n_i, 2))
      else $error("operation began inside a frame");
   AST_DONE:
   assert property ($fell(busy_o) |-> !write_enable_o)
      else $error("latch kept after operation");
   AST_WEL_SET:
   assert property ($rose(write_enable_o) |-> sel_n_i && !busy_o)
      else $error("latch set mid-frame or busy");
   AST_QUIET:
   assert property (busy_o |-> !io_line_1_oe_o)
      else $error("read served while busy");
   cover property ($rose(busy_o));
   cover property ($rose(io_line_0_oe_o));
   cover property ($rose(write_enable_o));
endmodule
bind flash_engine flash_engine_props props (
   .clk_i(clk_i), .srst_i(srst_i), .sel_n_i(sel_n_i),
   .io_line_0_oe_o(io_line_0_oe_o), .io_line_1_oe_o(io_line_1_oe_o),
   .busy_o(busy_o), .write_enable_o(write_enable_o));

// [tb/flash_host.sv]
// host model of the serial link: select, serial clock, io lines
// assumes the bench calls its tasks; every change lands on a clk_i fall
`timescale 1ns/1ps
module flash_host
   import flash_pkg::*;
(
   input wire logic clk_i,
   input wire logic dev0_i,
   input wire logic dev0_oe_i,
   input wire logic dev1_i,
   input wire logic dev1_oe_i,
   output logic sel_n_o,
   output logic sck_o,
   output logic line0_o,
   output logic line1_o
);
   logic d0, d1, e0, e1, tog;
   // a released line toggles so a stale bit never passes for data
   assign line0_o = dev0_oe_i ? dev0_i : (e0 ? d0 : tog);
   assign line1_o = dev1_oe_i ? dev1_i : (e1 ? d1 : tog);
   initial begin
      {sel_n_o, sck_o, d0, d1, e0, e1, tog} = 7'h40;
      forever @(negedge clk_i) tog = ~tog;
   end
   task half();
      repeat (4) @(negedge clk_i);
   endtask
   // msb first, a dual unit has its odd bit on line 1
   task send(input logic [7:0] b, input bit dual, input bit rel,
         input int n = 8);
      for (int i = 0; i < (dual ? 4 : n); i++) begin
         if (dual) begin
            {d1, d0} = b[7-2*i -: 2];
            e1 = 1'b1;
         end else begin
            d0 = b[7-i];
         end
         half();
         sck_o = 1'b1;
         half();
         // let go before the fall that opens the data phase
         if (rel && i == (dual ? 3 : n - 1)) {e0, e1} = 2'h0;
         sck_o = 1'b0;
      end
   endtask
   task recv(output logic [7:0] b, input bit dual);
      for (int i = 0; i < (dual ? 4 : 8); i++) begin
         half();
         sck_o = 1'b1;
         half();
         b = dual ? {b[5:0], line1_o, line0_o} : {b[6:0], line1_o};
         sck_o = 1'b0;
      end
   endtask
   task open(input logic [7:0] op, input int n = 8);
      sel_n_o = 1'b0;
      e0 = 1'b1;
      half();
      send(op, 1'b0, 1'b0, n);
   endtask
   // select rises and ends the frame; pending writes start here
   task close();
      half();
      {sel_n_o, e0, e1} = 3'h4;
      repeat (8) @(negedge clk_i);
   endtask
   task rd(input logic [7:0] op, input logic [23:0] a,
         output logic [7:0] b0, output logic [7:0] b1);
      bit da;
      bit dd;
      da = op == OP_DUAL_IO;
      dd = da || op == OP_DUAL_OUT;
      open(op);
      for (int k = 2; k >= 0; k--) send(a[8*k +: 8], da, 1'b0);
      if (op != OP_READ) send(8'h00, da, dd);
      recv(b0, dd);
      recv(b1, dd);
      close();
   endtask
endmodule

// [tb/flash_engine_tb.sv]
// self-checking bench for the flash instruction engine
// assumes the host model drives the link; all timers cut to 10 cycles
`timescale 1ns/1ps
module flash_engine_tb;
   import flash_pkg::*;
   logic clk_i, srst_i, sel_n, sck, l0, l1, o0, oe0, o1, oe1;
   logic pen, busy, wel;
   logic [23:0] pfrom;
   logic [7:0] b0, b1;
   int mismatches, checked;
   // {opcode, address, byte 0, byte 1}; image 1ffe=a1 1fff=b2 1f00=c3
   logic [47:0] rows [5] = '{
      48'h03_001ffe_a1_b2,
      48'h0b_001ffe_a1_b2,
      48'h3b_001fff_b2_ff,
      48'hbb_001eff_ff_c3,
      48'h03_ffffff_b2_ff};
   flash_host host (.clk_i(clk_i), .dev0_i(o0), .dev0_oe_i(oe0),
      .dev1_i(o1), .dev1_oe_i(oe1), .sel_n_o(sel_n), .sck_o(sck),
      .line0_o(l0), .line1_o(l1));
   flash_engine #(.ADDR_W(13), .PP_CYCLES(10), .SE_CYCLES(10),
      .BE_CYCLES(10), .CE_CYCLES(10)) uut (
      .clk_i(clk_i), .srst_i(srst_i), .sel_n_i(sel_n), .sck_i(sck),
      .io_line_0_i(l0), .io_line_0_o(o0), .io_line_0_oe_o(oe0),
      .io_line_1_i(l1), .io_line_1_o(o1), .io_line_1_oe_o(oe1),
      .protect_en_i(pen), .protect_from_i(pfrom), .busy_o(busy),
      .write_enable_o(wel));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task write_enable_cmd();
      host.open(OP_WRITE_ENABLE);
      host.close();
   endtask
   task wr(input logic [7:0] op, input logic [23:0] a, input bit has_a);
      host.open(op);
      if (has_a) for (int k = 2; k >= 0; k--) host.send(a[8*k +: 8], 0, 0);
   endtask
   // ends the frame, then waits out any self-timed operation
   task op_done(input logic run);
      int n;
      host.close();
      chk({7'h0, busy}, {7'h0, run});
      n = 0;
      while (busy !== 1'b0 && n < 80000) begin
         @(negedge clk_i);
         n++;
      end
      chk({7'h0, busy}, 8'h00);
      if (run) chk({7'h0, wel}, 8'h00);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      #3900000;
      mismatches++;
      test_done();
   end
   initial begin
      srst_i = 1'b1;
      pen = 1'b0;
      pfrom = 24'h001000;
      mismatches = 0;
      checked = 0;
      repeat (6) @(negedge clk_i);
      srst_i = 1'b0;
      repeat (6) @(negedge clk_i);
      chk({4'h0, oe1, oe0, busy, wel}, 8'h00);
      host.open(OP_WRITE_ENABLE, 6);
      host.close();
      chk({7'h0, wel}, 8'h00);
      write_enable_cmd();
      chk({7'h0, wel}, 8'h01);
      wr(OP_CHIP_ERASE_A, 24'h0, 0);
      host.close();
      // a read while busy must stay silent, watched by the checker
      host.rd(OP_READ, 24'h0, b0, b1);
      op_done(1);
      write_enable_cmd();
      wr(OP_PAGE_PROG, 24'h001ffe, 1);
      host.send(8'ha1, 0, 0);
      host.send(8'hb2, 0, 0);
      host.send(8'hc3, 0, 0);
      host.send(8'h5a, 0, 0, 5);
      op_done(1);
      for (int i = 0; i < 5; i++) begin
         host.rd(rows[i][47:40], rows[i][39:16], b0, b1);
         chk(b0, rows[i][15:8]);
         chk(b1, rows[i][7:0]);
      end
      wr(OP_PAGE_PROG, 24'h000010, 1);
      host.send(8'h00, 0, 0);
      op_done(0);
      pen = 1'b1;
      write_enable_cmd();
      wr(OP_PAGE_PROG, 24'h001200, 1);
      host.send(8'h00, 0, 0);
      op_done(0);
      wr(OP_CHIP_ERASE_B, 24'h0, 0);
      op_done(0);
      // protection on, but the sector ends below the threshold
      write_enable_cmd();
      wr(OP_SECTOR_ERASE_A, 24'h000abc, 1);
      op_done(1);
      host.rd(OP_READ, 24'h001ffe, b0, b1);
      chk(b0, 8'ha1);
      pfrom = 24'h002000;
      write_enable_cmd();
      wr(OP_SECTOR_ERASE_B, 24'h001234, 1);
      op_done(1);
      host.rd(OP_FAST_READ, 24'h001ffe, b0, b1);
      chk(b1, 8'hff);
      pen = 1'b0;
      write_enable_cmd();
      wr(OP_BLOCK_ERASE, 24'h00a5a5, 1);
      op_done(1);
      test_done();
   end
endmodule
